// ### src/uart2_pkg.sv
// Constants, field positions and state types of the second serial port
package uart2_pkg;

  // Special-function register addresses on the core's SFR port
  localparam logic [7:0] ADDR_CONTROL = 8'hE1;
  localparam logic [7:0] ADDR_BUFFER  = 8'hEB;
  localparam logic [7:0] ADDR_BAUD    = 8'hEE;

  // Values after reset
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BUFFER_RESET  = 8'h00;
  localparam logic [7:0] BAUD_RESET    = 8'h00;
  localparam logic [7:0] READ_IDLE     = 8'h00;

  // Control register field positions
  localparam int CTL_NINE_BIT  = 6;
  localparam int CTL_OVERRUN   = 5;
  localparam int CTL_FRAMING   = 4;
  localparam int CTL_BREAK     = 3;
  localparam int CTL_RX_ENABLE = 2;
  localparam int CTL_TX_DONE   = 1;
  localparam int CTL_RX_DONE   = 0;

  // Baud control register field positions
  localparam int BAUD_TX_NINTH  = 7;
  localparam int BAUD_RX_NINTH  = 6;
  localparam int BAUD_FRAC_SEL  = 5;
  localparam int BAUD_EXT_HI    = 4;
  localparam int BAUD_EXT_LO    = 3;
  localparam int BAUD_DIV_HI    = 2;
  localparam int BAUD_DIV_LO    = 0;

  // Fractional divider values picked by fraction_select
  localparam logic [5:0] FRAC_WHEN_SET   = 6'h2B;
  localparam logic [5:0] FRAC_WHEN_CLEAR = 6'h07;
  // Phase step of the baud accumulator (the fraction denominator)
  localparam logic [17:0] PHASE_STEP     = 18'h00040;

  // Oversampling counts in baud ticks, and frame counts in bits
  localparam logic [3:0] TICK_LAST   = 4'hF;  // 16 ticks per bit
  localparam logic [3:0] TICK_MID    = 4'h7;  // Start bit midpoint
  localparam logic [7:0] BREAK_TICKS = 8'hA8; // 10.5 bits of 16 ticks
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [3:0] FRAME_LEN_8 = 4'hA;
  localparam logic [3:0] FRAME_LEN_9 = 4'hB;
  localparam logic [3:0] TX_DONE_BIT = 4'h8;  // Index of last of eight data bits

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_BITS  = 4'h4,
    RX_BREAK = 4'h8
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h1,
    TX_SHIFT = 2'h2
  } tx_state_t;

endpackage : uart2_pkg

// ### src/baud_if.sv
// Baud timer settings and oversampling tick between port and timer
`timescale 1ns/100ps
interface baud_if;
  logic [2:0] binary_divider;
  logic [1:0] extended_divider;
  logic       fraction_select;
  logic       tick;

  modport timer (input binary_divider, input extended_divider, input fraction_select, output tick);
  modport user  (output binary_divider, output extended_divider, output fraction_select, input tick);
endinterface : baud_if

// ### src/baud_timer.sv
// Fractional baud timer producing the sixteen-times oversampling tick
`timescale 1ns/100ps
module baud_timer (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // Settings in, tick out
  baud_if.timer     bif
);

  logic [17:0] phase_r;
  logic        tick_r;
  wire  [3:0]  shift_amt;
  wire  [5:0]  frac;
  wire  [17:0] threshold;
  wire  [17:0] phase_sum;
  wire         wrap;
  wire         stale;

  // Period of one tick is 2^n * (1 + frac/64) core cycles
  assign shift_amt = {1'b0, bif.binary_divider} + {2'b00, bif.extended_divider};
  assign frac      = bif.fraction_select ? uart2_pkg::FRAC_WHEN_SET
                                         : uart2_pkg::FRAC_WHEN_CLEAR;
  assign threshold = {11'h000, 1'b1, frac} << shift_amt;
  assign phase_sum = phase_r + uart2_pkg::PHASE_STEP;
  assign wrap      = phase_sum >= threshold;
  // Phase left above a newly shortened period restarts at zero instead of bursting ticks
  assign stale     = phase_r >= threshold;

  // Accumulator keeps the remainder so the fraction does not drift
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= 18'h00000;
      tick_r  <= 1'b0;
    end else begin
      phase_r <= stale ? 18'h00000 : wrap ? phase_sum - threshold : phase_sum;
      tick_r  <= wrap & ~stale;
    end
  end

  assign bif.tick = tick_r;

endmodule : baud_timer

// ### src/uart2_core.sv
// Second serial port: SFR file, transmitter, receiver and error flags
`timescale 1ns/100ps
module uart2_core (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Core SFR port
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  // Extended mode from the system configuration register
  input  wire logic       extended_mode_enable,
  // Serial pins
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin
);

  baud_if bif ();

  // Register state
  logic [7:0]            control_r;
  logic [7:0]            control_nxt;
  logic [7:0]            baud_r;
  logic [7:0]            baud_nxt;
  logic [7:0]            rx_buffer_r;
  logic [7:0]            rdata_r;

  // Receiver state
  uart2_pkg::rx_state_t  rx_state_r;
  uart2_pkg::rx_state_t  rx_state_nxt;
  logic                  rx_s1_r;
  logic                  rx_s2_r;
  logic                  rx_s3_r;
  logic                  rx_line_r;
  logic [3:0]            rx_sub_r;
  logic [3:0]            rx_cnt_r;
  logic [8:0]            rx_shift_r;
  logic [7:0]            low_cnt_r;

  // Transmitter state
  uart2_pkg::tx_state_t  tx_state_r;
  logic [10:0]           tx_shift_r;
  logic [3:0]            tx_sub_r;
  logic [3:0]            tx_cnt_r;
  logic [3:0]            tx_len_r;
  logic                  tx_out_r;

  // Field views
  wire nine_bit_select = control_r[uart2_pkg::CTL_NINE_BIT];
  wire overrun_flag    = control_r[uart2_pkg::CTL_OVERRUN];
  wire rx_enable_bit   = control_r[uart2_pkg::CTL_RX_ENABLE];
  wire rx_done_flag    = control_r[uart2_pkg::CTL_RX_DONE];
  wire tx_ninth_bit    = baud_r[uart2_pkg::BAUD_TX_NINTH];

  // Address decode for the three SFRs
  wire sel_control = sfr_addr == uart2_pkg::ADDR_CONTROL;
  wire sel_buffer  = sfr_addr == uart2_pkg::ADDR_BUFFER;
  wire sel_baud    = sfr_addr == uart2_pkg::ADDR_BAUD;
  wire wr_control  = sfr_wr & sel_control;
  wire wr_buffer   = sfr_wr & sel_buffer;
  wire wr_baud     = sfr_wr & sel_baud;

  // Baud timer settings and tick
  assign bif.binary_divider   = baud_r[uart2_pkg::BAUD_DIV_HI:uart2_pkg::BAUD_DIV_LO];
  assign bif.extended_divider = baud_r[uart2_pkg::BAUD_EXT_HI:uart2_pkg::BAUD_EXT_LO];
  assign bif.fraction_select  = baud_r[uart2_pkg::BAUD_FRAC_SEL];
  wire tick = bif.tick;

  baud_timer u_baud_timer (
    .mclk    (mclk),
    .reset_n (reset_n),
    .bif     (bif)
  );

  // ---------------- Receiver ----------------

  // Filtered line changes only once two late stages agree
  wire rx_stable   = rx_s2_r == rx_s3_r;
  wire rx_fall     = rx_line_r & rx_stable & ~rx_s3_r;
  wire [3:0] rx_data_n = nine_bit_select ? uart2_pkg::DATA_BITS_9 : uart2_pkg::DATA_BITS_8;
  wire rx_bit_end  = tick & (rx_sub_r == uart2_pkg::TICK_LAST);
  wire rx_mid      = tick & (rx_sub_r == uart2_pkg::TICK_MID);
  wire rx_stop_smp = (rx_state_r == uart2_pkg::RX_BITS) & rx_bit_end & (rx_cnt_r == rx_data_n);
  wire stop_bit    = rx_line_r;
  wire [7:0] rx_byte = nine_bit_select ? rx_shift_r[7:0] : rx_shift_r[8:1];
  wire rx_ninth    = nine_bit_select ? rx_shift_r[8] : stop_bit;
  // Data bits shift in until the count reaches the frame's width
  wire rx_shift_en = (rx_state_r == uart2_pkg::RX_BITS) & rx_bit_end & (rx_cnt_r != rx_data_n);

  // Held byte is replaced only when empty or in extended mode
  wire rx_arrive   = rx_stop_smp;
  wire rx_accept   = rx_arrive & (~rx_done_flag | extended_mode_enable);
  wire rx_lost     = rx_arrive & rx_done_flag;
  wire brk_long    = (rx_state_r == uart2_pkg::RX_BREAK) & (low_cnt_r > uart2_pkg::BREAK_TICKS);
  wire brk_short   = (rx_state_r == uart2_pkg::RX_BREAK) & rx_line_r;

  // Receiver sequencing
  always_comb begin
    rx_state_nxt = rx_state_r;
    unique case (rx_state_r)
      uart2_pkg::RX_IDLE: begin
        if (rx_fall && rx_enable_bit) begin
          rx_state_nxt = uart2_pkg::RX_START;
        end
      end
      uart2_pkg::RX_START: begin
        if (rx_mid) begin
          rx_state_nxt = rx_line_r ? uart2_pkg::RX_IDLE : uart2_pkg::RX_BITS;
        end
      end
      uart2_pkg::RX_BITS: begin
        if (rx_stop_smp) begin
          rx_state_nxt = stop_bit ? uart2_pkg::RX_IDLE : uart2_pkg::RX_BREAK;
        end
      end
      uart2_pkg::RX_BREAK: begin
        if (brk_long || brk_short) begin
          rx_state_nxt = uart2_pkg::RX_IDLE;
        end
      end
    endcase
  end

  // Three-stage input synchroniser and filtered line
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_r   <= 1'b1;
      rx_s2_r   <= 1'b1;
      rx_s3_r   <= 1'b1;
      rx_line_r <= 1'b1;
    end else begin
      rx_s1_r <= serial_in_pin;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_stable) begin
        rx_line_r <= rx_s3_r;
      end
    end
  end

  // Receiver state register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_r <= uart2_pkg::RX_IDLE;
    end else begin
      rx_state_r <= rx_state_nxt;
    end
  end

  // Oversampling counter; restarting at the start midpoint keeps later samples centred
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sub_r <= 4'h0;
    end else if (rx_state_r == uart2_pkg::RX_IDLE) begin
      rx_sub_r <= 4'h0;
    end else if (rx_state_r == uart2_pkg::RX_START && rx_mid) begin
      rx_sub_r <= 4'h0;                    // Realign to bit middle
    end else if (tick) begin
      rx_sub_r <= rx_sub_r + 4'h1;
    end
  end

  // Bit counter and shift register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_cnt_r   <= 4'h0;
      rx_shift_r <= 9'h000;
    end else if (rx_state_r == uart2_pkg::RX_IDLE) begin
      rx_cnt_r <= 4'h0;
    end else if (rx_shift_en) begin
      rx_shift_r <= {rx_line_r, rx_shift_r[8:1]}; // LSB arrives first
      rx_cnt_r   <= rx_cnt_r + 4'h1;
    end
  end

  // Low-time counter for break detection, saturating
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_r <= 8'h00;
    end else if (rx_line_r) begin
      low_cnt_r <= 8'h00;
    end else if (tick && low_cnt_r != 8'hFF) begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end

  // Receive holding buffer, separate from transmit data
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_buffer_r <= uart2_pkg::BUFFER_RESET;
    end else if (rx_accept) begin
      rx_buffer_r <= rx_byte;
    end
  end

  // ---------------- Transmitter ----------------

  // Writes while a frame is going out are ignored, which avoids a torn frame
  wire tx_start   = wr_buffer & (tx_state_r == uart2_pkg::TX_IDLE);
  wire tx_bit_end = (tx_state_r == uart2_pkg::TX_SHIFT) & tick & (tx_sub_r == uart2_pkg::TICK_LAST);
  wire tx_last    = tx_bit_end & (tx_cnt_r == tx_len_r - 4'h1);
  wire tx_done    = tx_bit_end & (tx_cnt_r == uart2_pkg::TX_DONE_BIT);
  wire tx_ninth   = nine_bit_select ? tx_ninth_bit : 1'b1;

  // Shift register, bit count and line level
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_r <= uart2_pkg::TX_IDLE;
      tx_shift_r <= 11'h7FF;
      tx_cnt_r   <= 4'h0;
      tx_len_r   <= uart2_pkg::FRAME_LEN_8;
      tx_out_r   <= 1'b1;
    end else if (tx_start) begin
      // Stop, ninth, data, start; low bit goes out first
      tx_shift_r <= {1'b1, tx_ninth, sfr_wdata, 1'b0};
      tx_len_r   <= nine_bit_select ? uart2_pkg::FRAME_LEN_9 : uart2_pkg::FRAME_LEN_8;
      tx_cnt_r   <= 4'h0;
      tx_out_r   <= 1'b0;
      tx_state_r <= uart2_pkg::TX_SHIFT;
    end else if (tx_last) begin
      tx_out_r   <= 1'b1;
      tx_state_r <= uart2_pkg::TX_IDLE;
    end else if (tx_bit_end) begin
      tx_shift_r <= {1'b1, tx_shift_r[10:1]};
      tx_out_r   <= tx_shift_r[1];
      tx_cnt_r   <= tx_cnt_r + 4'h1;
    end
  end

  // Tick counter within the current transmit bit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sub_r <= 4'h0;
    end else if (tx_start || tx_bit_end) begin
      tx_sub_r <= 4'h0;
    end else if (tick && tx_state_r == uart2_pkg::TX_SHIFT) begin
      tx_sub_r <= tx_sub_r + 4'h1;
    end
  end

  // ---------------- Registers ----------------

  // Control register: hardware sets win over a software write in the same cycle
  always_comb begin
    control_nxt = control_r;
    if (wr_control) begin
      control_nxt[uart2_pkg::CTL_NINE_BIT]  = sfr_wdata[uart2_pkg::CTL_NINE_BIT];
      control_nxt[uart2_pkg::CTL_RX_ENABLE] = sfr_wdata[uart2_pkg::CTL_RX_ENABLE];
      control_nxt[uart2_pkg::CTL_TX_DONE]   = sfr_wdata[uart2_pkg::CTL_TX_DONE];
      control_nxt[uart2_pkg::CTL_RX_DONE]   = sfr_wdata[uart2_pkg::CTL_RX_DONE];
      // Writing one leaves the overrun flag alone; only zero clears it
      control_nxt[uart2_pkg::CTL_OVERRUN]   = overrun_flag & sfr_wdata[uart2_pkg::CTL_OVERRUN];
    end
    if (rx_lost) begin
      control_nxt[uart2_pkg::CTL_OVERRUN] = 1'b1;
    end
    if (rx_arrive) begin
      control_nxt[uart2_pkg::CTL_FRAMING] = ~stop_bit;
      if (stop_bit) begin
        control_nxt[uart2_pkg::CTL_BREAK] = 1'b0;
      end
    end
    // A break ends either by a long low or by the line rising
    if (brk_long) begin
      control_nxt[uart2_pkg::CTL_BREAK] = 1'b1;
    end else if (brk_short) begin
      control_nxt[uart2_pkg::CTL_BREAK] = 1'b0;
    end
    if (rx_accept) begin
      control_nxt[uart2_pkg::CTL_RX_DONE] = 1'b1;
    end
    if (tx_done) begin
      control_nxt[uart2_pkg::CTL_TX_DONE] = 1'b1;
    end
    control_nxt[7] = 1'b0;                                 // Reserved reads zero
  end

  // Baud control register: received ninth bit is hardware-only
  always_comb begin
    baud_nxt = baud_r;
    if (wr_baud) begin
      baud_nxt = sfr_wdata;
      baud_nxt[uart2_pkg::BAUD_RX_NINTH] = baud_r[uart2_pkg::BAUD_RX_NINTH];
    end
    if (rx_accept) begin
      baud_nxt[uart2_pkg::BAUD_RX_NINTH] = rx_ninth;
    end
  end

  // Register file state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      control_r <= uart2_pkg::CONTROL_RESET;
      baud_r    <= uart2_pkg::BAUD_RESET;
    end else begin
      control_r <= control_nxt;
      baud_r    <= baud_nxt;
    end
  end

  // Read mux; unmapped addresses read zero, data is valid the cycle after
  wire [7:0] rd_mux = sel_control ? control_r :
                      sel_buffer  ? rx_buffer_r :
                      sel_baud    ? baud_r :
                                    uart2_pkg::READ_IDLE;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= uart2_pkg::READ_IDLE;
    end else if (sfr_rd) begin
      rdata_r <= rd_mux;
    end
  end

  // Both outputs come straight from flip-flops
  assign sfr_rdata      = rdata_r;
  assign serial_out_pin = tx_out_r;

endmodule : uart2_core

// ### tb/uart2_core_properties.sv
// Concurrent checks on the second serial port's SFR port and pins
`timescale 1ns/100ps
module uart2_core_properties (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // SFR port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Mode and serial pins
  input wire logic       extended_mode_enable,
  input wire logic       serial_in_pin,
  input wire logic       serial_out_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Decoded accesses
  wire ctl_wr   = sfr_wr && sfr_addr == uart2_pkg::ADDR_CONTROL;
  wire ctl_rd   = sfr_rd && !sfr_wr && sfr_addr == uart2_pkg::ADDR_CONTROL;
  wire baud_wr  = sfr_wr && sfr_addr == uart2_pkg::ADDR_BAUD;
  wire baud_rd  = sfr_rd && !sfr_wr && sfr_addr == uart2_pkg::ADDR_BAUD;
  wire unmapped = sfr_addr != uart2_pkg::ADDR_CONTROL && sfr_addr != uart2_pkg::ADDR_BUFFER
                  && sfr_addr != uart2_pkg::ADDR_BAUD;

  // Last written byte, kept so a read-back can be tied to its write
  logic [7:0] wdata_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) wdata_r <= 8'h00;
    else if (sfr_wr) wdata_r <= sfr_wdata;
  end

  AST_RDATA_HOLDS: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("Read data moved without a read");
  AST_UNMAPPED_ZERO: assert property (sfr_rd && unmapped |=> sfr_rdata == 8'h00)
    else $error("Unmapped read not zero");
  AST_RESERVED_ZERO: assert property (ctl_rd |=> !sfr_rdata[7])
    else $error("Reserved control bit reads one");
  AST_CONTROL_RW: assert property (ctl_wr ##1 !sfr_wr ##1 ctl_rd |=>
    sfr_rdata[6] == wdata_r[6] && sfr_rdata[2] == wdata_r[2]) else $error("Control bits not written");
  AST_BAUD_RW: assert property (baud_wr ##1 !sfr_wr ##1 baud_rd |=>
    sfr_rdata[7] == wdata_r[7] && sfr_rdata[5:0] == wdata_r[5:0]) else $error("Baud settings not written");
  // Even a phase-shortened first bit spans at least fifteen clocks
  AST_LOW_BIT_HOLDS: assert property ($fell(serial_out_pin) |=> !serial_out_pin [*8])
    else $error("Low bit on transmit line too short");
  AST_HIGH_BIT_HOLDS: assert property ($rose(serial_out_pin) |=> serial_out_pin [*8])
    else $error("High bit on transmit line too short");
  AST_IDLE_AFTER_RESET: assert property ($rose(reset_n) |-> serial_out_pin)
    else $error("Transmit line not idle after reset");

  // Main scenarios
  cover property (sfr_wr && sfr_addr == uart2_pkg::ADDR_BUFFER);
  cover property (ctl_rd ##1 sfr_rdata[5]);
  cover property ($fell(serial_in_pin));
  cover property (extended_mode_enable && sfr_rd && sfr_addr == uart2_pkg::ADDR_BUFFER);
endmodule : uart2_core_properties

bind uart2_core uart2_core_properties chk (.mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .extended_mode_enable(extended_mode_enable), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin));

// ### tb/remote_serial.sv
// Far-end serial device: frames into the receive pin, captures the transmit pin
`timescale 1ns/100ps
module remote_serial (
  // Clock
  input  wire logic mclk,
  // Serial lines
  input  wire logic line_from_port,
  output logic      line_to_port
);
  initial line_to_port = 1'b1;

  // Fractional bit times are kept exact by waiting to a running target
  task automatic until_t(ref int n, input real t);
    while (n < t) begin
      @(posedge mclk);
      n++;
    end
  endtask : until_t

  // Start low, data LSB first, stop; line optionally held at stop level
  task automatic send(input logic [8:0] d, input int nb, input logic stp, input real bitc, input int hold);
    int n;
    n = 0;
    for (int k = 0; k <= nb + 1 + hold; k++) begin
      line_to_port <= (k == 0) ? 1'b0 : (k <= nb) ? d[k-1] : stp;
      until_t(n, (k + 1) * bitc);
    end
    line_to_port <= 1'b1;
  endtask : send

  // Samples each bit at its middle; ok stays low if no start appears in time
  task automatic capture(input int nb, input real bitc, output logic [8:0] d, output logic stp, output bit ok);
    int n;
    n = 0;
    d = 9'h000;
    stp = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 4000 && line_from_port; i++) @(posedge mclk);
    if (line_from_port) return;
    until_t(n, bitc / 2);
    ok = !line_from_port;
    for (int k = 1; k <= nb + 1; k++) begin
      until_t(n, bitc / 2 + k * bitc);
      if (k <= nb) d[k-1] = line_from_port;
      else stp = line_from_port;
    end
  endtask : capture
endmodule : remote_serial

// ### tb/second_uart_with_error_flags_tb.sv
// Self-checking bench for the second serial port
`timescale 1ns/100ps
module second_uart_with_error_flags_tb;
  localparam logic [7:0] CTL  = uart2_pkg::ADDR_CONTROL;
  localparam logic [7:0] BUF  = uart2_pkg::ADDR_BUFFER;
  localparam logic [7:0] BAUD = uart2_pkg::ADDR_BAUD;
  localparam real        BIT8 = 17.75; // Clocks per bit at divide 1, fraction 0x07
  logic       mclk;
  logic       reset_n;
  logic       sfr_wr;
  logic       sfr_rd;
  logic       extended_mode_enable;
  logic       serial_in_pin;
  logic       serial_out_pin;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [8:0] cap;
  logic       stp;
  bit         ok;
  int         failures;
  int         comparisons;

  uart2_core uut (.mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .extended_mode_enable(extended_mode_enable),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin));
  remote_serial far (.mclk(mclk), .line_from_port(serial_out_pin), .line_to_port(serial_in_pin));

  // Core clock, 5 ns period
  always #2.5 mclk = ~mclk;

  task automatic tally_and_finish;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // A bounded wait that ran out ends the run
  task automatic need(input bit c);
    if (!c) begin
      failures++;
      $display("Error at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask : need

  // SFR write; an idle edge after it keeps back-to-back writes from reassigning the strobe in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    @(posedge mclk);
    check({1'b0, sfr_rdata & m}, {1'b0, e});
  endtask : expect_reg

  // Polls rx_done_flag a bounded number of times; always reads afresh so stale read data cannot end it
  task automatic wait_rx;
    expect_reg(CTL, 8'h00, 8'h00);
    for (int i = 0; i < 100 && sfr_rdata[0] !== 1'b1; i++) expect_reg(CTL, 8'h00, 8'h00);
    need(sfr_rdata[0] === 1'b1);
  endtask : wait_rx

  // Reset values, read-only bits and an unmapped place
  task automatic s_registers;
    expect_reg(CTL, 8'hFF, 8'h00);
    expect_reg(BUF, 8'hFF, 8'h00);
    expect_reg(BAUD, 8'hFF, 8'h00);
    wr(8'hE2, 8'hFF);
    expect_reg(8'hE2, 8'hFF, 8'h00);
    wr(CTL, 8'h98);
    expect_reg(CTL, 8'hFF, 8'h00);
    wr(BAUD, 8'hFF);
    expect_reg(BAUD, 8'hFF, 8'hBF);
  endtask : s_registers

  // One transmitted frame at a given mode and rate
  task automatic tx_case(input logic [7:0] c, input logic [7:0] b, input int nb, input real bitc, input logic [8:0] d);
    wr(CTL, c);
    wr(BAUD, b);
    wr(BUF, d[7:0]);
    far.capture(nb, bitc, cap, stp, ok);
    need(ok);
    check(cap, d);
    check({8'h00, stp}, 9'h001);
    expect_reg(CTL, 8'h02, 8'h02);
    wr(CTL, c);
    expect_reg(CTL, 8'h02, 8'h00);
    repeat (int'(bitc)) @(posedge mclk);
  endtask : tx_case

  // Both directions at once, then arrivals onto an unread byte
  task automatic s_duplex;
    wr(CTL, 8'h04);
    wr(BAUD, 8'h00);
    fork
      far.send(9'h03C, 8, 1'b1, BIT8, 0);
      begin
        wr(BUF, 8'hC3);
        far.capture(8, BIT8, cap, stp, ok);
      end
    join
    check(cap, 9'h0C3);
    wait_rx();
    expect_reg(BUF, 8'hFF, 8'h3C);
    expect_reg(CTL, 8'hFF, 8'h07);
    expect_reg(BAUD, 8'h40, 8'h40);
    far.send(9'h081, 8, 1'b1, BIT8, 0);
    expect_reg(CTL, 8'h20, 8'h20);
    expect_reg(BUF, 8'hFF, 8'h3C);
    extended_mode_enable <= 1'b1;
    far.send(9'h099, 8, 1'b1, BIT8, 0);
    expect_reg(BUF, 8'hFF, 8'h99);
    extended_mode_enable <= 1'b0;
    wr(CTL, 8'h04);
    expect_reg(CTL, 8'hFF, 8'h04);
    wr(CTL, 8'h00);
    far.send(9'h055, 8, 1'b1, BIT8, 0);
    repeat (40) @(posedge mclk);
    expect_reg(CTL, 8'h01, 8'h00);
  endtask : s_duplex

  // Missing stop bit, a held-low line, then a clean frame in 9-bit mode
  task automatic s_errors;
    wr(CTL, 8'h04);
    far.send(9'h05A, 8, 1'b0, BIT8, 0);
    wait_rx();
    expect_reg(CTL, 8'h18, 8'h10);
    expect_reg(BAUD, 8'h40, 8'h00);
    wr(CTL, 8'h04);
    far.send(9'h000, 8, 1'b0, BIT8, 2);
    wait_rx();
    expect_reg(CTL, 8'h18, 8'h18);
    wr(CTL, 8'h44);
    far.send(9'h0A5, 9, 1'b1, BIT8, 0);
    wait_rx();
    expect_reg(CTL, 8'h18, 8'h00);
    expect_reg(BUF, 8'hFF, 8'hA5);
    expect_reg(BAUD, 8'h40, 8'h00);
  endtask : s_errors

  // Main sequence
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    extended_mode_enable = 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    s_registers();
    tx_case(8'h00, 8'h00, 8, BIT8, 9'h0A5);
    tx_case(8'h40, 8'hA0, 9, 26.75, 9'h13C);
    tx_case(8'h40, 8'h09, 9, 71.0, 9'h05B);
    tx_case(8'h00, 8'h03, 8, 142.0, 9'h0E1);
    s_duplex();
    s_errors();
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    expect_reg(CTL, 8'hFF, 8'h00);
    tally_and_finish();
  end
endmodule : second_uart_with_error_flags_tb
